// >>> core/adcr_regbank.sv
// control register bank of a stereo audio adc
// assumes write words come deserialised and synchronous to core_clk_i
`timescale 1ns/10ps
module adcr_regbank
  import adcr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // control word strobe
  input wire logic wr_valid_i,
  input wire adcr_word_t wr_word_i,
  // decoded controls
  output adcr_cfg_t cfg_o,
  // frame and bit clock roles
  output logic frame_clock_oe_o,
  output logic bit_clock_oe_o,
  // raw stored words, index order timeout..mux
  output adcr_regs_t regs_o,
  output logic sw_reset_o
);
  localparam adcr_regs_t RESET_VALS = {RST_MUX, RST_LIMIT, RST_NGATE, RST_LVLT, RST_LVL2, RST_LVL1,
    RST_GAIN, RST_GAIN, RST_POWER, RST_CLOCKING, RST_IFACE, RST_TIMEOUT};
  localparam logic [NUM_REGS-1:0][6:0] ADDRS = {ADDR_MUX, ADDR_LIMIT, ADDR_NGATE, ADDR_LVLT,
    ADDR_LVL2, ADDR_LVL1, ADDR_RGAIN, ADDR_LGAIN, ADDR_POWER, ADDR_CLOCKING, ADDR_IFACE,
    ADDR_TIMEOUT};

  adcr_regs_t regs;
  adcr_regs_t next_regs;
  logic sw_reset;
  logic next_sw_reset;
  logic reset_hit;
  logic [NUM_REGS-1:0] addr_hit;

  // address in the upper seven bits, data in the lower nine
  assign reset_hit = wr_valid_i && (wr_word_i.addr == ADDR_SWRESET);

  // one comparator per stored word; an unmapped address hits none and is dropped
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_word
    assign addr_hit[g] = wr_valid_i && (wr_word_i.addr == ADDRS[g]);

    word_store_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      addr_hit[g] |=> regs[g] == $past(wr_word_i.data))
      else $error("mapped write not stored");
    word_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !addr_hit[g] && !reset_hit |=> regs[g] == $past(regs[g]))
      else $error("stored word changed without a write");
  end

  // undefined bits are stored as written; the host keeps them zero
  always_comb begin
    next_regs = regs;
    next_sw_reset = reset_hit;
    if (reset_hit) begin
      next_regs = RESET_VALS;
    end else if (wr_valid_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (addr_hit[i]) begin
          next_regs[i] = wr_word_i.data;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      regs <= RESET_VALS;
      sw_reset <= 1'b0;
    end else begin
      regs <= next_regs;
      sw_reset <= next_sw_reset;
    end
  end

  adcr_cfg_decode adcr_cfg_decode_inst (
    .timeout_i(regs[0]),
    .iface_i(regs[1]),
    .clocking_i(regs[2]),
    .cfg_o(cfg_o)
  );

  assign regs_o = regs;
  assign sw_reset_o = sw_reset;
  // master drives both clocks, slave takes them in
  assign frame_clock_oe_o = regs[2][BIT_ROLE];
  assign bit_clock_oe_o = regs[2][BIT_ROLE];

  sequence swr_write_s;
    wr_valid_i && wr_word_i.addr == ADDR_SWRESET;
  endsequence

  swr_restores_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    swr_write_s |=> regs == RESET_VALS && sw_reset)
    else $error("software reset did not restore defaults");
  iface_write_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    wr_valid_i && wr_word_i.addr == ADDR_IFACE |=> regs[1] == $past(wr_word_i.data))
    else $error("interface write not stored");
  timeout_off_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cfg_o.zero_cross_timeout_off == regs[0][3])
    else $error("timeout off mismatch");
  fmt_decode_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    wr_valid_i && wr_word_i.addr == ADDR_IFACE |=> cfg_o.frame_format_select == $past(wr_word_i.data[1:0]))
    else $error("format decode wrong");
  pol_nondsp_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[1][1:0] != 2'h3 |-> cfg_o.frame_clock_invert == regs[1][2] && !cfg_o.dsp_variant_b)
    else $error("frame polarity wrong");
  dsp_variant_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[1][1:0] == 2'h3 |-> cfg_o.dsp_variant_b == regs[1][2] && !cfg_o.frame_clock_invert)
    else $error("dsp variant wrong");
  bclk_pol_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cfg_o.bit_clock_polarity == regs[1][3])
    else $error("bit clock polarity wrong");
  width_sel_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cfg_o.sample_width_select == regs[1][5:4])
    else $error("width select wrong");
  mclk_hpf_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cfg_o.master_clock_polarity == regs[1][6] && cfg_o.highpass_filter_off == regs[1][8])
    else $error("mclk or hpf bit wrong");
  role_oe_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    frame_clock_oe_o == cfg_o.interface_role_select && bit_clock_oe_o == cfg_o.interface_role_select)
    else $error("clock role wrong");
  ratio_map_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[2][2:0] == 3'h2 |-> cfg_o.clock_ratio == 10'd256)
    else $error("ratio 256 wrong");

  sequence timeout_write_s;
    wr_valid_i && wr_word_i.addr == ADDR_TIMEOUT;
  endsequence

  sequence iface_write_s;
    wr_valid_i && wr_word_i.addr == ADDR_IFACE;
  endsequence

  sequence clocking_write_s;
    wr_valid_i && wr_word_i.addr == ADDR_CLOCKING;
  endsequence

  // bit 2 of the interface word has two meanings, picked by the format code
  sequence iface_dsp_write_s;
    iface_write_s ##0 wr_word_i.data[1:0] == 2'h3;
  endsequence

  sequence iface_framed_write_s;
    iface_write_s ##0 wr_word_i.data[1:0] != 2'h3;
  endsequence

  swr_pulse_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    sw_reset_o |-> $past(reset_hit))
    else $error("reset pulse without a reset write");
  swr_single_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    swr_write_s ##1 !reset_hit |=> !sw_reset_o)
    else $error("reset pulse longer than one cycle");
  idle_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !wr_valid_i |=> regs == $past(regs) && !sw_reset_o)
    else $error("registers moved without a write");
  unmapped_drop_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    wr_valid_i && addr_hit == '0 && !reset_hit |=> regs == $past(regs))
    else $error("unmapped write changed a register");

  timeout_store_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    timeout_write_s |=> cfg_o.zero_cross_timeout_off == $past(wr_word_i.data[BIT_TIMEOUT_OFF]))
    else $error("timeout off not taken from the write");

  framed_pol_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    iface_framed_write_s |=> cfg_o.frame_clock_invert == $past(wr_word_i.data[BIT_POLARITY])
      && !cfg_o.dsp_variant_b)
    else $error("frame polarity not taken from the write");
  dsp_store_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    iface_dsp_write_s |=> cfg_o.dsp_variant_b == $past(wr_word_i.data[BIT_POLARITY])
      && !cfg_o.frame_clock_invert)
    else $error("dsp variant not taken from the write");
  bit2_excl_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !(cfg_o.frame_clock_invert && cfg_o.dsp_variant_b))
    else $error("bit 2 decoded both ways");
  bclk_normal_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    iface_write_s ##0 !wr_word_i.data[BIT_BCLK_POL] |=> !cfg_o.bit_clock_polarity)
    else $error("bit clock polarity not normal");
  bclk_invert_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    iface_write_s ##0 wr_word_i.data[BIT_BCLK_POL] |=> cfg_o.bit_clock_polarity)
    else $error("bit clock polarity not inverted");
  width_store_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    iface_write_s |=> cfg_o.sample_width_select == $past(wr_word_i.data[5:4]))
    else $error("width not taken from the write");
  mclk_store_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    iface_write_s |=> cfg_o.master_clock_polarity == $past(wr_word_i.data[BIT_MCLK_POL]))
    else $error("mclk polarity not taken from the write");
  hpf_store_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    iface_write_s |=> cfg_o.highpass_filter_off == $past(wr_word_i.data[BIT_HPF_OFF]))
    else $error("hpf off not taken from the write");

  fmt_right_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[1][1:0] == 2'h0 |-> cfg_o.frame_format_select == FMT_RIGHT)
    else $error("format code 0 wrong");
  fmt_left_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[1][1:0] == 2'h1 |-> cfg_o.frame_format_select == FMT_LEFT)
    else $error("format code 1 wrong");
  fmt_i2s_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[1][1:0] == 2'h2 |-> cfg_o.frame_format_select == FMT_I2S)
    else $error("format code 2 wrong");
  fmt_dsp_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[1][1:0] == 2'h3 |-> cfg_o.frame_format_select == FMT_DSP)
    else $error("format code 3 wrong");

  wl_16_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[1][5:4] == 2'h0 |-> cfg_o.sample_width_select == WL_16)
    else $error("width code 0 wrong");
  wl_20_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[1][5:4] == 2'h1 |-> cfg_o.sample_width_select == WL_20)
    else $error("width code 1 wrong");
  wl_24_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[1][5:4] == 2'h2 |-> cfg_o.sample_width_select == WL_24)
    else $error("width code 2 wrong");
  wl_32_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[1][5:4] == 2'h3 |-> cfg_o.sample_width_select == WL_32)
    else $error("width code 3 wrong");

  role_store_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    clocking_write_s |=> frame_clock_oe_o == $past(wr_word_i.data[BIT_ROLE])
      && bit_clock_oe_o == frame_clock_oe_o)
    else $error("role not taken from the write");
  rate_store_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    clocking_write_s |=> cfg_o.clock_ratio_select == $past(wr_word_i.data[2:0]))
    else $error("rate code not taken from the write");
  ratio_384_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[2][2:0] == 3'h3 |-> cfg_o.clock_ratio == 10'd384)
    else $error("ratio 384 wrong");
  ratio_512_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[2][2:0] == 3'h4 |-> cfg_o.clock_ratio == 10'd512)
    else $error("ratio 512 wrong");
  ratio_768_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[2][2:0] == 3'h5 |-> cfg_o.clock_ratio == 10'd768)
    else $error("ratio 768 wrong");
  // codes outside the documented set give no ratio rather than a guess
  ratio_other_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    regs[2][2:0] < 3'h2 || regs[2][2:0] > 3'h5 |-> cfg_o.clock_ratio == 10'd0)
    else $error("undefined ratio code not zero");
endmodule : adcr_regbank

// >>> core/adcr_pkg.sv
// package for the audio adc control register bank: offsets, resets, field layout
// assumes control words arrive already deserialised, one 16-bit word per strobe
// Functional notes
// - timeout register bit 3: 0 keeps zero-cross timeout, 1 switches it off
// - interface bits 1:0 select framing: right, left, i2s, dsp
// - in non-dsp framing bit 2 inverts frame clock polarity
// - in dsp framing bit 2 picks dsp variant a or b
// - bit clock polarity 0: sample frame clock rising, change data falling
// - bit clock polarity 1: sample frame clock falling, change data rising
// - interface bits 5:4 select sample width 16, 20, 24 or 32
// - interface bit 6 inverts the master clock input
// - any write to the reset address restores every field default
// - interface bit 8 set disables the high-pass filter
// - clocking bit 8 selects slave (clocks in) or master (clocks driven)
// - master rate bits 2:0 give ratio 256, 384, 512 or 768
package adcr_pkg;
  localparam logic [6:0] ADDR_TIMEOUT = 7'h07;
  localparam logic [6:0] ADDR_IFACE = 7'h0b;
  localparam logic [6:0] ADDR_CLOCKING = 7'h0c;
  localparam logic [6:0] ADDR_POWER = 7'h0d;
  localparam logic [6:0] ADDR_LGAIN = 7'h0e;
  localparam logic [6:0] ADDR_RGAIN = 7'h0f;
  localparam logic [6:0] ADDR_LVL1 = 7'h10;
  localparam logic [6:0] ADDR_LVL2 = 7'h11;
  localparam logic [6:0] ADDR_LVLT = 7'h12;
  localparam logic [6:0] ADDR_NGATE = 7'h13;
  localparam logic [6:0] ADDR_LIMIT = 7'h14;
  localparam logic [6:0] ADDR_MUX = 7'h15;
  localparam logic [6:0] ADDR_SWRESET = 7'h17;
  localparam int NUM_REGS = 12;
  localparam logic [8:0] RST_TIMEOUT = 9'h000;
  localparam logic [8:0] RST_IFACE = 9'h022;
  localparam logic [8:0] RST_CLOCKING = 9'h022;
  // printed power default does not fit nine bits; low nine bits are kept
  localparam logic [8:0] RST_POWER = 9'h000;
  localparam logic [8:0] RST_GAIN = 9'h0cf;
  localparam logic [8:0] RST_LVL1 = 9'h07b;
  localparam logic [8:0] RST_LVL2 = 9'h000;
  localparam logic [8:0] RST_LVLT = 9'h032;
  localparam logic [8:0] RST_NGATE = 9'h000;
  localparam logic [8:0] RST_LIMIT = 9'h0a6;
  localparam logic [8:0] RST_MUX = 9'h001;
  localparam int WORD_ADDR_LSB = 9;
  localparam int BIT_TIMEOUT_OFF = 3;
  localparam int BIT_POLARITY = 2;
  localparam int BIT_BCLK_POL = 3;
  localparam int BIT_MCLK_POL = 6;
  localparam int BIT_HPF_OFF = 8;
  localparam int BIT_ROLE = 8;
  typedef enum logic [1:0] {FMT_RIGHT, FMT_LEFT, FMT_I2S, FMT_DSP} adcr_fmt_t;
  typedef enum logic [1:0] {WL_16, WL_20, WL_24, WL_32} adcr_wl_t;
  typedef enum logic [2:0] {
    RATE_R0, RATE_R1, RATE_256, RATE_384, RATE_512, RATE_768, RATE_R6, RATE_R7
  } adcr_rate_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [8:0] data;
  } adcr_word_t;
  typedef struct packed {
    logic zero_cross_timeout_off;
    adcr_fmt_t frame_format_select;
    logic frame_clock_invert;
    logic dsp_variant_b;
    logic bit_clock_polarity;
    adcr_wl_t sample_width_select;
    logic master_clock_polarity;
    logic highpass_filter_off;
    logic interface_role_select;
    adcr_rate_t clock_ratio_select;
    logic [9:0] clock_ratio;
  } adcr_cfg_t;
  typedef logic [NUM_REGS-1:0][8:0] adcr_regs_t;
endpackage : adcr_pkg

// >>> core/adcr_cfg_decode.sv
// decodes the stored interface and clocking words into named controls
// assumes inputs come straight from the register flops
`timescale 1ns/10ps
module adcr_cfg_decode
  import adcr_pkg::*;
(
  // stored words
  input wire logic [8:0] timeout_i,
  input wire logic [8:0] iface_i,
  input wire logic [8:0] clocking_i,
  // decoded controls
  output adcr_cfg_t cfg_o
);
  always_comb begin
    cfg_o = '0;
    cfg_o.zero_cross_timeout_off = timeout_i[BIT_TIMEOUT_OFF];
    cfg_o.frame_format_select = adcr_fmt_t'(iface_i[1:0]);
    // bit 2 means one thing or the other, never both
    if (iface_i[1:0] == FMT_DSP) begin
      cfg_o.dsp_variant_b = iface_i[BIT_POLARITY];
    end else begin
      cfg_o.frame_clock_invert = iface_i[BIT_POLARITY];
    end
    cfg_o.bit_clock_polarity = iface_i[BIT_BCLK_POL];
    cfg_o.sample_width_select = adcr_wl_t'(iface_i[5:4]);
    cfg_o.master_clock_polarity = iface_i[BIT_MCLK_POL];
    cfg_o.highpass_filter_off = iface_i[BIT_HPF_OFF];
    cfg_o.interface_role_select = clocking_i[BIT_ROLE];
    cfg_o.clock_ratio_select = adcr_rate_t'(clocking_i[2:0]);
    case (adcr_rate_t'(clocking_i[2:0]))
      RATE_256: cfg_o.clock_ratio = 10'd256;
      RATE_384: cfg_o.clock_ratio = 10'd384;
      RATE_512: cfg_o.clock_ratio = 10'd512;
      RATE_768: cfg_o.clock_ratio = 10'd768;
      default: cfg_o.clock_ratio = 10'd0;
    endcase
  end
endmodule : adcr_cfg_decode

// >>> test/adcr_host_model.sv
// host model: hands control words to the register bank, one per strobe
// assumes the bank takes a word on the rising edge where the strobe is high
`timescale 1ns/10ps
module adcr_host_model
  import adcr_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // write strobe
  output logic wr_valid_o,
  output adcr_word_t wr_word_o
);
  initial begin
    wr_valid_o = 1'b0;
    wr_word_o = '0;
  end
  // callers pass zero in undefined bits
  task automatic write_word(input logic [6:0] addr, input logic [8:0] data);
    @(posedge core_clk_i);
    wr_valid_o <= 1'b1;
    wr_word_o <= '{addr: addr, data: data};
    @(posedge core_clk_i);
    wr_valid_o <= 1'b0;
    // word is not held once the strobe drops, so a stale sample cannot pass
    wr_word_o <= ~wr_word_o;
  endtask : write_word
endmodule : adcr_host_model

// >>> test/audio_adc_control_register_map_tb.sv
// testbench for the adc control register bank
// assumes the host model drives every write word
`timescale 1ns/10ps
module audio_adc_control_register_map_tb
  import adcr_pkg::*;;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr_valid_i;
  adcr_word_t wr_word_i;
  adcr_cfg_t cfg_o;
  logic frame_clock_oe_o;
  logic bit_clock_oe_o;
  logic sw_reset_o;
  adcr_regs_t regs_o;
  adcr_regs_t dflt;
  int num_errors = 0;
  int total_checks = 0;
  assign dflt = {RST_MUX, RST_LIMIT, RST_NGATE, RST_LVLT, RST_LVL2, RST_LVL1, RST_GAIN, RST_GAIN, RST_POWER,
    RST_CLOCKING, RST_IFACE, RST_TIMEOUT};
  always #12.5 core_clk_i = ~core_clk_i;
  adcr_regbank adcr_regbank_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .wr_valid_i(wr_valid_i),
    .wr_word_i(wr_word_i), .cfg_o(cfg_o), .frame_clock_oe_o(frame_clock_oe_o), .bit_clock_oe_o(bit_clock_oe_o),
    .regs_o(regs_o), .sw_reset_o(sw_reset_o));
  adcr_host_model adcr_host_model_inst (.core_clk_i(core_clk_i), .wr_valid_o(wr_valid_i), .wr_word_o(wr_word_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic chk_all(input adcr_regs_t exp);
    for (int i = 0; i < NUM_REGS; i++) chk(regs_o[i], exp[i]);
  endtask : chk_all
  // settle one step past the edge that lands the write
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    adcr_host_model_inst.write_word(a, d);
    #1;
  endtask : wr
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    #100us;
    num_errors++;
    conclude();
  end
  initial begin
    adcr_regs_t exp;
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk_all(dflt);
    chk({frame_clock_oe_o, bit_clock_oe_o}, 0);
    $display("test defaults done");
    wr(ADDR_TIMEOUT, 9'h008);
    chk(cfg_o.zero_cross_timeout_off, 1);
    wr(ADDR_TIMEOUT, 9'h000);
    chk(cfg_o.zero_cross_timeout_off, 0);
    $display("test timeout done");
    // width code follows the format code, so 32-bit never meets right-justified
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_IFACE, {1'b1, 1'b0, 1'b1, f[1:0], f[0], 1'b1, f[1:0]});
      chk(cfg_o.frame_format_select, f);
      chk(cfg_o.frame_clock_invert, f != 3);
      chk(cfg_o.dsp_variant_b, f == 3);
      chk(cfg_o.bit_clock_polarity, f % 2);
      chk(cfg_o.sample_width_select, f);
      chk({cfg_o.master_clock_polarity, cfg_o.highpass_filter_off}, 3);
    end
    wr(ADDR_IFACE, 9'h000);
    chk({cfg_o.master_clock_polarity, cfg_o.highpass_filter_off}, 0);
    $display("test interface done");
    for (int r = 0; r < 8; r++) begin
      wr(ADDR_CLOCKING, 9'h120 | 9'(r));
      chk(cfg_o.clock_ratio, (r >= 2 && r <= 5) ? 128 * (r + (r == 5)) : 0);
      chk(cfg_o.clock_ratio_select, r);
      chk(cfg_o.interface_role_select, 1);
      chk({frame_clock_oe_o, bit_clock_oe_o}, 3);
    end
    wr(ADDR_CLOCKING, RST_CLOCKING);
    chk({frame_clock_oe_o, bit_clock_oe_o}, 0);
    $display("test clocking done");
    wr(ADDR_LGAIN, 9'h155);
    wr(ADDR_RGAIN, 9'h0aa);
    wr(7'h16, 9'h1ff);
    exp = dflt;
    exp[1] = 9'h000;
    exp[4] = 9'h155;
    exp[5] = 9'h0aa;
    chk_all(exp);
    $display("test gains done");
    wr(ADDR_SWRESET, 9'h000);
    chk(sw_reset_o, 1);
    @(posedge core_clk_i);
    #1;
    chk(sw_reset_o, 0);
    chk_all(dflt);
    $display("test software reset done");
    wr(ADDR_RGAIN, 9'h011);
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    #1;
    chk_all(dflt);
    chk(sw_reset_o, 0);
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk_all(dflt);
    wr(ADDR_RGAIN, 9'h011);
    chk(regs_o[5], 9'h011);
    $display("test hardware reset done");
    conclude();
  end
endmodule : audio_adc_control_register_map_tb
